// ---- aetu_defs.vh ----
`ifndef AETU_DEFS_VH
`define AETU_DEFS_VH

// ****************************************************************
// Register map of the plain register port.
// ****************************************************************
`define AETU_ADDR_CTRL3 4'h0
`define AETU_ADDR_CTRL 4'h1
`define AETU_ADDR_LTH 4'h2
`define AETU_ADDR_UTH 4'h3
`define AETU_ADDR_SETPOINT_VALUE 4'h4
`define AETU_ADDR_ERR 4'h5
`define AETU_ADDR_STAT 4'h6

// ****************************************************************
// Field positions.
// ****************************************************************
`define AETU_ERROR_SELECT_A_HI 6
`define AETU_ERROR_SELECT_A_LO 4
`define AETU_SOT_BIT 3
`define AETU_TMD_HI 2
`define AETU_TMD_LO 0
`define AETU_CTRL_GO 0
`define AETU_CTRL_CONTINUOUS_CONVERT 1
`define AETU_CTRL_DOUBLE_SAMPLE_ENABLE 2
`define AETU_CTRL_PREV_SAMPLE_SELECT 3

// ****************************************************************
// Reset values.
// ****************************************************************
`define AETU_CTRL3_RST 8'h00
`define AETU_CTRL_RST 8'h00
`define AETU_WORD_RST 16'h0000

// ****************************************************************
// Calculation and threshold mode codes.
// ****************************************************************
`define AETU_ERROR_SELECT_A_RES_PREV 3'h0
`define AETU_ERROR_SELECT_A_RES_SETPOINT_VALUE 3'h1
`define AETU_ERROR_SELECT_A_RES_FLT 3'h2
`define AETU_ERROR_SELECT_A_PREV_FLT 3'h4
`define AETU_ERROR_SELECT_A_FLT_SETPOINT_VALUE 3'h5
`define AETU_TMD_NEVER 3'h0
`define AETU_TMD_LT_L 3'h1
`define AETU_TMD_GE_L 3'h2
`define AETU_TMD_INSIDE 3'h3
`define AETU_TMD_OUTSIDE 3'h4
`define AETU_TMD_LE_U 3'h5
`define AETU_TMD_GT_U 3'h6
`define AETU_TMD_ALWAYS 3'h7

`endif

// ---- aetu_error_threshold.v ----
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

`include "aetu_defs.vh"

module aetu_error_threshold #(
    parameter DW = 16
) (
    core_clk,
    sys_rst,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    conv_done,
    conversion_result,
    first_sample,
    second_sample,
    filtered_value,
    conv_go,
    retrigger,
    threshold_irq,
    error_value
);
    input wire core_clk;
    input wire sys_rst;
    input wire [3:0] reg_addr;
    input wire [DW-1:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [DW-1:0] reg_rdata;
    input wire conv_done;
    input wire [DW-1:0] conversion_result;
    input wire [DW-1:0] first_sample;
    input wire [DW-1:0] second_sample;
    input wire [DW-1:0] filtered_value;
    output reg conv_go;
    output reg retrigger;
    output reg threshold_irq;
    output reg [DW-1:0] error_value;

    // ************************************************************
    // Register map and timing overview.
    // ************************************************************
    // Address 0 is control register three. Bit 7 always reads zero.
    // Bits 6 to 4 pick the error formula.
    // Bit 3 is the stop-on-threshold bit for continuous runs.
    // Bits 2 to 0 pick the threshold test that raises the interrupt.
    //
    // Address 1 is the main control register.
    // Bit 0 is the go bit; software sets it to arm a conversion.
    // Bit 1 selects continuous conversion.
    // Bit 2 selects double-sample capacitive mode.
    // Bit 3 is the previous-sample select.
    // Bits 7 to 4 always read zero.
    //
    // Address 2 holds the lower threshold, a signed word.
    // Address 3 holds the upper threshold, a signed word.
    // Address 4 holds the setpoint.
    // Address 5 shows the last error value and ignores writes.
    // Address 6 is status: bit 0 is a sticky interrupt-seen flag.
    // Writing a one to bit 0 clears the sticky flag.
    // Bit 1 of status mirrors the registered go output.
    // Every other address reads as zero and ignores writes.
    //
    // A completion pulse is only acted on while the go bit is set.
    // The error, interrupt and retrigger outputs appear one cycle later.
    // The registered go output trails the go bit by one more cycle.
    // Software that polls the go output must allow for that lag.
    //
    // Without continuous mode every accepted completion clears go.
    // With continuous mode and the stop bit set, go is cleared only
    // when the threshold test passes; otherwise a retrigger pulse
    // asks the converter for the next sample.
    // With continuous mode and the stop bit clear, hardware never
    // clears go, so software must clear it to end the run.
    //
    // A hardware clear of go beats a software write in the same
    // cycle. This costs software one extra write in a rare race,
    // but a stop decision taken by the threshold test is never lost.
    //
    // The sticky flag is set by a passing test and cleared by
    // software; if both happen in one cycle the set wins, so an
    // event that races the clear is still reported.
    //
    // All arithmetic wraps at the word width. Comparisons against the
    // thresholds treat both sides as two's complement values, so a
    // negative error sits below any non-negative threshold.
    //
    // Reserved formula codes give an error of zero. That keeps the
    // output defined, but the value carries no meaning.
    //
    // Read data is registered and stands only in the cycle after the
    // read strobe; it is zero in every other cycle.

    // ************************************************************
    // Arithmetic helper.
    // ************************************************************

    // Two's complement difference; wraps like the converter's own math.
    function [DW-1:0] diff;
        input [DW-1:0] a;
        input [DW-1:0] b;
        begin
            diff = a - b;
        end
    endfunction

    // ************************************************************
    // Control registers.
    // ************************************************************
    reg [7:0] ctrl3_q;
    reg [7:0] ctrl_q;
    reg [DW-1:0] lower_threshold_q;
    reg [DW-1:0] upper_threshold_q;
    reg [DW-1:0] setpoint_value_q;
    reg [DW-1:0] prev_result_q;
    reg irq_seen_q;

    wire [2:0] error_select_a;
    wire stop_on_threshold;
    wire [2:0] threshold_irq_mode;
    wire continuous_convert;
    wire double_sample_enable;
    wire prev_sample_select;

    assign error_select_a = ctrl3_q[`AETU_ERROR_SELECT_A_HI:`AETU_ERROR_SELECT_A_LO];
    assign stop_on_threshold = ctrl3_q[`AETU_SOT_BIT];
    assign threshold_irq_mode = ctrl3_q[`AETU_TMD_HI:`AETU_TMD_LO];
    assign continuous_convert = ctrl_q[`AETU_CTRL_CONTINUOUS_CONVERT];
    assign double_sample_enable = ctrl_q[`AETU_CTRL_DOUBLE_SAMPLE_ENABLE];
    assign prev_sample_select = ctrl_q[`AETU_CTRL_PREV_SAMPLE_SELECT];

    // ************************************************************
    // Error computation.
    // ************************************************************
    reg [DW-1:0] delta;
    reg [DW-1:0] err_d;

    // The difference term comes from the two samples in double-sample mode with the previous
    // select clear, otherwise from the stored last result.
    always @* begin
        if (double_sample_enable && !prev_sample_select) begin
            delta = diff(second_sample, first_sample);
        end else begin
            delta = diff(conversion_result, prev_result_q);
        end
    end

    // Reserved codes fall back to zero so the output is at least stable.
    always @* begin
        case (error_select_a)
            `AETU_ERROR_SELECT_A_RES_PREV: begin
                err_d = delta;
            end
            `AETU_ERROR_SELECT_A_RES_SETPOINT_VALUE: begin
                if (double_sample_enable) begin
                    err_d = diff(delta, setpoint_value_q);
                end else begin
                    err_d = diff(conversion_result, setpoint_value_q);
                end
            end
            `AETU_ERROR_SELECT_A_RES_FLT: begin
                if (double_sample_enable) begin
                    err_d = diff(delta, filtered_value);
                end else begin
                    err_d = diff(conversion_result, filtered_value);
                end
            end
            `AETU_ERROR_SELECT_A_PREV_FLT: begin
                err_d = diff(prev_result_q, filtered_value);
            end
            `AETU_ERROR_SELECT_A_FLT_SETPOINT_VALUE: begin
                err_d = diff(filtered_value, setpoint_value_q);
            end
            default: begin
                err_d = {DW{1'b0}};
            end
        endcase
    end

    // ************************************************************
    // Threshold test, signed comparison.
    // ************************************************************
    wire below_l;
    wire above_u;
    reg hit;

    assign below_l = $signed(err_d) < $signed(lower_threshold_q);
    assign above_u = $signed(err_d) > $signed(upper_threshold_q);

    always @* begin
        case (threshold_irq_mode)
            `AETU_TMD_NEVER: hit = 1'b0;
            `AETU_TMD_LT_L: hit = below_l;
            `AETU_TMD_GE_L: hit = !below_l;
            `AETU_TMD_INSIDE: begin
                hit = ($signed(err_d) > $signed(lower_threshold_q)) &&
                      ($signed(err_d) < $signed(upper_threshold_q));
            end
            `AETU_TMD_OUTSIDE: hit = below_l || above_u;
            `AETU_TMD_LE_U: hit = !above_u;
            `AETU_TMD_GT_U: hit = above_u;
            `AETU_TMD_ALWAYS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // ************************************************************
    // Register writes and conversion-completion handling.
    // ************************************************************

    // A completion that clears go in the same cycle as a software write to the control
    // register wins for the go bit, so a stop decision is never lost.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl3_q <= `AETU_CTRL3_RST;
            ctrl_q <= `AETU_CTRL_RST;
            lower_threshold_q <= `AETU_WORD_RST;
            upper_threshold_q <= `AETU_WORD_RST;
            setpoint_value_q <= `AETU_WORD_RST;
            prev_result_q <= `AETU_WORD_RST;
            error_value <= `AETU_WORD_RST;
            threshold_irq <= 1'b0;
            irq_seen_q <= 1'b0;
            retrigger <= 1'b0;
            conv_go <= 1'b0;
        end else begin
            threshold_irq <= 1'b0;
            retrigger <= 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    `AETU_ADDR_CTRL3: ctrl3_q <= {1'b0, reg_wdata[6:0]};
                    `AETU_ADDR_CTRL: ctrl_q <= {4'h0, reg_wdata[3:0]};
                    `AETU_ADDR_LTH: lower_threshold_q <= reg_wdata;
                    `AETU_ADDR_UTH: upper_threshold_q <= reg_wdata;
                    `AETU_ADDR_SETPOINT_VALUE: setpoint_value_q <= reg_wdata;
                    `AETU_ADDR_STAT: begin
                        if (reg_wdata[0]) begin
                            irq_seen_q <= 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (conv_done && ctrl_q[`AETU_CTRL_GO]) begin
                error_value <= err_d;
                prev_result_q <= conversion_result;
                threshold_irq <= hit;
                if (hit) begin
                    irq_seen_q <= 1'b1;
                end
                if (continuous_convert) begin
                    if (stop_on_threshold && hit) begin
                        ctrl_q[`AETU_CTRL_GO] <= 1'b0;
                    end else begin
                        retrigger <= 1'b1;
                    end
                end else begin
                    ctrl_q[`AETU_CTRL_GO] <= 1'b0;
                end
            end
            conv_go <= ctrl_q[`AETU_CTRL_GO];
        end
    end

    // ************************************************************
    // Read port: data in the cycle after the read strobe.
    // ************************************************************
    always @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= {DW{1'b0}};
        end else if (reg_rd) begin
            case (reg_addr)
                `AETU_ADDR_CTRL3: reg_rdata <= {{(DW-8){1'b0}}, ctrl3_q};
                `AETU_ADDR_CTRL: reg_rdata <= {{(DW-8){1'b0}}, ctrl_q};
                `AETU_ADDR_LTH: reg_rdata <= lower_threshold_q;
                `AETU_ADDR_UTH: reg_rdata <= upper_threshold_q;
                `AETU_ADDR_SETPOINT_VALUE: reg_rdata <= setpoint_value_q;
                `AETU_ADDR_ERR: reg_rdata <= error_value;
                `AETU_ADDR_STAT: begin
                    reg_rdata <= {{(DW-2){1'b0}}, conv_go, irq_seen_q};
                end
                default: reg_rdata <= {DW{1'b0}};
            endcase
        end else begin
            reg_rdata <= {DW{1'b0}};
        end
    end

endmodule // aetu_error_threshold

// ---- aetu_checker_sva.sv ----
`timescale 1ns/1ps
`include "aetu_defs.vh"
// ****************************************************************
// Port checker for the error and threshold unit.
// ****************************************************************
module aetu_checker #(
    parameter DW = 16
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [3:0] reg_addr,
    input wire [DW-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire conv_done,
    input wire conv_go,
    input wire retrigger,
    input wire threshold_irq,
    input wire [DW-1:0] error_value
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    reg [3:0] mode_q;
    reg continuous_convert_q;
    // Shadow of stop bit, test mode and continuous bit, seen from writes.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            mode_q <= 4'h0;
            continuous_convert_q <= 1'b0;
        end else if (reg_wr && reg_addr == `AETU_ADDR_CTRL3) begin
            mode_q <= reg_wdata[3:0];
        end else if (reg_wr && reg_addr == `AETU_ADDR_CTRL) begin
            continuous_convert_q <= reg_wdata[`AETU_CTRL_CONTINUOUS_CONVERT];
        end
    end
    // Guards on past writes keep a racing software go write out of scope.
    property p_irq_cause; threshold_irq |-> $past(conv_done); endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq without a completion");
    property p_retrig; retrigger |-> $past(conv_done) && $past(continuous_convert_q);
    endproperty
    a_retrig: assert property (p_retrig)
        else $error("retrigger outside continuous completion");
    property p_err_hold; !$stable(error_value) |-> $past(conv_done);
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("error value moved without completion");
    property p_never; conv_done && mode_q[2:0] == `AETU_TMD_NEVER
        |=> !threshold_irq; endproperty
    a_never: assert property (p_never)
        else $error("irq in never mode");
    property p_always; conv_done && conv_go && !reg_wr && !$past(reg_wr)
        && !$past(conv_done) && mode_q[2:0] == `AETU_TMD_ALWAYS
        |=> threshold_irq; endproperty
    a_always: assert property (p_always)
        else $error("no irq in always mode");
    property p_stop; threshold_irq && $past(mode_q[3]) && $past(continuous_convert_q)
        |-> !retrigger ##1 !conv_go; endproperty
    a_stop: assert property (p_stop)
        else $error("go not cleared on threshold stop");
    property p_continuous_convert; conv_done && conv_go && !reg_wr && !$past(reg_wr)
        && !$past(conv_done) && continuous_convert_q && !mode_q[3]
        |=> retrigger ##1 conv_go; endproperty
    a_continuous_convert: assert property (p_continuous_convert)
        else $error("continuous run stopped by hardware");
    property p_ignored; conv_done && !conv_go && !$past(reg_wr)
        |=> !threshold_irq && !retrigger && $stable(error_value);
    endproperty
    a_ignored: assert property (p_ignored)
        else $error("completion acted on while go is low");
endmodule // aetu_checker

bind aetu_error_threshold aetu_checker #(.DW(DW)) u_chk (.*);

// ---- adc_error_threshold_unit_test.sv ----
`timescale 1ns/1ps
`include "aetu_defs.vh"
// ****************************************************************
// Self-checking bench for the error and threshold unit.
// ****************************************************************
module adc_error_threshold_unit_test;
    reg core_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg conv_done = 1'b0;
    reg [15:0] res = 16'h0000, s1 = 16'h0000, s2 = 16'h0000;
    reg [15:0] flt = 16'h0000, prev = 16'h0000;
    wire [15:0] reg_rdata, error_value;
    wire conv_go, retrigger, threshold_irq;
    integer bad_count = 0, compares = 0, cycles = 0;
    aetu_error_threshold u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
        .conversion_result(res), .first_sample(s1), .second_sample(s2),
        .filtered_value(flt), .conv_go(conv_go), .retrigger(retrigger),
        .threshold_irq(threshold_irq), .error_value(error_value));
    // Clock, and a cycle ceiling so a hang still reaches the verdict.
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            bad_count = bad_count + 1;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input [15:0] e, input [15:0] g);
        compares = compares + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, input [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", e, reg_rdata);
    endtask
    // One completion pulse; returns where the answer cycle has settled.
    task conv(input [15:0] r, b, f);
        @(posedge core_clk);
        conv_done <= 1'b1;
        res <= r;
        s1 <= 16'h0040;
        s2 <= b;
        flt <= f;
        @(posedge core_clk);
        conv_done <= 1'b0;
        #1;
    endtask
    // Expected error with the previous-sample select left at zero.
    function [15:0] ex_err(input [2:0] c, input ds, input [15:0] r, b, f);
        reg [15:0] d, x;
        begin
            d = ds ? b - 16'h0040 : r - prev;
            x = ds ? d : r;
            case (c)
                `AETU_ERROR_SELECT_A_RES_PREV: ex_err = d;
                `AETU_ERROR_SELECT_A_RES_SETPOINT_VALUE: ex_err = x - 16'h0003;
                `AETU_ERROR_SELECT_A_RES_FLT: ex_err = x - f;
                `AETU_ERROR_SELECT_A_PREV_FLT: ex_err = prev - f;
                `AETU_ERROR_SELECT_A_FLT_SETPOINT_VALUE: ex_err = f - 16'h0003;
                default: ex_err = 16'h0000;
            endcase
        end
    endfunction
    function hit(input [2:0] t, input signed [15:0] e);
        case (t)
            `AETU_TMD_NEVER: hit = 1'b0;
            `AETU_TMD_LT_L: hit = e < 16'sd10;
            `AETU_TMD_GE_L: hit = e >= 16'sd10;
            `AETU_TMD_INSIDE: hit = e > 16'sd10 && e < 16'sd20;
            `AETU_TMD_OUTSIDE: hit = e < 16'sd10 || e > 16'sd20;
            `AETU_TMD_LE_U: hit = e <= 16'sd20;
            `AETU_TMD_GT_U: hit = e > 16'sd20;
            default: hit = 1'b1;
        endcase
    endfunction
    task t_regs;
        rd(`AETU_ADDR_CTRL, 16'h0000);
        rd(4'hF, 16'h0000);
        rd(`AETU_ADDR_STAT, 16'h0000);
        wr(`AETU_ADDR_ERR, 16'h1234);
        rd(`AETU_ADDR_ERR, 16'h0000);
        wr(`AETU_ADDR_CTRL3, 16'h00D0);
        rd(`AETU_ADDR_CTRL3, 16'h0050);
        wr(`AETU_ADDR_LTH, 16'h000A);
        wr(`AETU_ADDR_UTH, 16'h0014);
        rd(`AETU_ADDR_LTH, 16'h000A);
    endtask
    // Every code in both sampling modes; reserved codes 7 and 6 run first.
    task t_error_select_a;
        integer i;
        reg [15:0] r, b, f, e;
        wr(`AETU_ADDR_SETPOINT_VALUE, 16'h0003);
        for (i = 15; i >= 0; i = i - 1) begin
            r = 16'h0100 + 16'h0013 * i[15:0];
            b = 16'h0090 + i[15:0];
            f = 16'h0080 - i[15:0];
            e = ex_err(i[3:1], i[0], r, b, f);
            wr(`AETU_ADDR_CTRL3, {9'h000, i[3:1], 4'h7});
            wr(`AETU_ADDR_CTRL, {13'h0000, i[0], 2'b01});
            conv(r, b, f);
            prev = r;
            chk("error", e, error_value);
            chk("irq", 16'h0001, {15'h0000, threshold_irq});
            rd(`AETU_ADDR_ERR, e);
        end
    endtask
    // Error equals the result; values straddle both thresholds.
    task t_tmd;
        integer t, k;
        reg [15:0] e;
        wr(`AETU_ADDR_SETPOINT_VALUE, 16'h0000);
        for (t = 0; t < 8; t = t + 1) for (k = 0; k < 5; k = k + 1) begin
            e = (k == 0) ? 16'hFFFB : 16'h000A + 16'h0005 * (k - 1);
            wr(`AETU_ADDR_CTRL3, {9'h002, 1'b0, t[2:0]});
            wr(`AETU_ADDR_CTRL, 16'h0001);
            conv(e, 16'h0000, 16'h0000);
            chk("irq", {15'h0000, hit(t[2:0], e)}, {15'h0000, threshold_irq});
        end
    endtask
    task t_continuous_convert;
        wr(`AETU_ADDR_CTRL3, 16'h001A);
        wr(`AETU_ADDR_CTRL, 16'h0003);
        conv(16'h0005, 16'h0000, 16'h0000);
        chk("retrigger", 16'h0001, {15'h0000, retrigger});
        conv(16'h000C, 16'h0000, 16'h0000);
        chk("retrigger", 16'h0000, {15'h0000, retrigger});
        @(posedge core_clk);
        #1 chk("go", 16'h0000, {15'h0000, conv_go});
        wr(`AETU_ADDR_CTRL3, 16'h0012);
        wr(`AETU_ADDR_CTRL, 16'h0003);
        conv(16'h000C, 16'h0000, 16'h0000);
        chk("retrigger", 16'h0001, {15'h0000, retrigger});
        @(posedge core_clk);
        #1 chk("go", 16'h0001, {15'h0000, conv_go});
        wr(`AETU_ADDR_CTRL, 16'h0002);
        @(posedge core_clk);
        #1 chk("go", 16'h0000, {15'h0000, conv_go});
        conv(16'h0777, 16'h0000, 16'h0000);
        chk("irq", 16'h0000, {15'h0000, threshold_irq});
        chk("error", 16'h000C, error_value);
    endtask
    // Double mode with previous select set uses the stored result.
    task t_misc;
        wr(`AETU_ADDR_CTRL3, 16'h0007);
        wr(`AETU_ADDR_CTRL, 16'h000D);
        conv(16'h0100, 16'h0000, 16'h0000);
        chk("error", 16'h00F4, error_value);
        rd(`AETU_ADDR_STAT, 16'h0001);
        wr(`AETU_ADDR_STAT, 16'h0001);
        rd(`AETU_ADDR_STAT, 16'h0000);
    endtask
    // Reset for four cycles, then the scenarios in turn.
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs;
        t_error_select_a;
        t_tmd;
        t_continuous_convert;
        t_misc;
        tally_and_finish;
    end
endmodule // adc_error_threshold_unit_test
